/* logic/ctcer_pkg.sv */
// Shared constants, field layouts and state types of the counter/timer block.
package ctcer_pkg;
	// Register byte offsets.
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_CLKEV = 8'h04;
	localparam logic [7:0] OFS_LIMIT = 8'h08;
	localparam logic [7:0] OFS_COUNT = 8'h0c;
	// Reset values and writable-bit masks.
	localparam logic [15:0] CTRL_RESET = 16'h0200;
	localparam logic [15:0] CLKEV_RESET = 16'h0000;
	localparam logic [15:0] LIMIT_RESET = 16'hffff;
	localparam logic [15:0] COUNT_RESET = 16'hffff;
	localparam logic [15:0] CTRL_WR_MASK = 16'h07ff;
	localparam logic [15:0] CLKEV_WR_MASK = 16'h0fef;
	localparam logic [15:0] CNT_MAX = 16'hffff;
	localparam logic [15:0] CNT_MIN = 16'h0000;
	localparam logic [15:0] CNT_ONE = 16'h0001;
	localparam logic [15:0] RD_ZERO = 16'h0000;
	// Prescaler width covers the slowest divide of 2 to the 7th.
	localparam int DIV_W = 7;
	localparam logic [DIV_W-1:0] DIV_RESET = 7'h00;
	localparam logic [DIV_W-1:0] DIV_ONE = 7'h01;

	typedef enum logic [1:0] {
		MODE_TIMER = 2'b00,
		MODE_EVENT = 2'b01,
		MODE_ONESHOT = 2'b10,
		MODE_MEASURE = 2'b11
	} ctcer_mode_t;

	typedef enum logic [1:0] {
		EDGE_FALL = 2'b00,
		EDGE_RISE = 2'b01,
		EDGE_BOTH = 2'b10,
		EDGE_NONE = 2'b11
	} ctcer_edge_t;

	// Control register at offset 0x00.
	typedef struct packed {
		logic [2:0] rsv;
		logic clk_req;
		logic sleep_en;
		logic out_polarity;
		logic power_down;
		logic filter_bypass;
		logic wrap_reload_control;
		logic out_enable;
		logic count_direction;
		logic input_polarity;
		ctcer_mode_t mode;
		logic soft_reset;
		logic enable;
	} ctcer_ctrl_t;

	// Clock and event control register at offset 0x04.
	typedef struct packed {
		logic [3:0] rsv_hi;
		logic [3:0] filter_clock_select;
		logic event_source;
		ctcer_edge_t edge_type;
		logic rsv_lo;
		logic [3:0] count_clock_select;
	} ctcer_clkev_t;

	// Whole state of the prescaler.
	typedef struct packed {
		logic [DIV_W-1:0] cnt;
	} ctcer_div_st_t;

	// Whole state of the timer instance.
	typedef struct packed {
		ctcer_ctrl_t ctrl;
		ctcer_clkev_t clkev;
		logic [15:0] limit;
		logic [15:0] lim_act;
		logic [15:0] count;
		logic [1:0] samp;
		logic filt;
		logic lvl_prev;
		logic os_run;
		logic wrap;
		logic [15:0] rdata;
	} ctcer_st_t;
endpackage

/* logic/ctcer_prescale.sv */
// Power-of-two prescaler that turns a four-bit clock select into a tick enable.
`timescale 1ns/10ps
module ctcer_prescale (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic clk_en,
	input wire logic [3:0] sel,
	output logic tick
);
	ctcer_pkg::ctcer_div_st_t st_ff;
	ctcer_pkg::ctcer_div_st_t nxt_st;
	logic [ctcer_pkg::DIV_W-1:0] mask;

	// One mask bit per divider stage, set below the selected stage.
	genvar i;
	generate
		for (i = 0; i < ctcer_pkg::DIV_W; i++)
		begin : g_mask
			assign mask[i] = (3'(i) < sel[2:0]);
		end
	endgenerate

	// A set top select bit is a reserved code and yields no tick at all.
	assign tick = ~sel[3] & ((st_ff.cnt & mask) == mask);

	// Free-running divider.
	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.cnt = st_ff.cnt + ctcer_pkg::DIV_ONE;
	end

	// State register, frozen while the clock enable is low.
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			st_ff.cnt <= ctcer_pkg::DIV_RESET;
		end
		else if (clk_en)
		begin
			st_ff <= nxt_st;
		end
	end
endmodule // ctcer_prescale

/* logic/ctcer_timer.sv */
// One 16-bit auto-reloading counter/timer instance with clock, edge and event selection.
// Summary of operation
// - Four-bit select picks the count rate, halving per code; top bit set is reserved.
// - Event mode counts falling, rising, both or no input edges by edge field.
// - One-shot edge field picks start edge, or immediate start on enable.
// - Measurement mode times between falling, rising, or all edges; 11 measures nothing.
// - Event source bit picks predecessor overflow (0) or filtered input pin (1).
// - Noise filter runs from its own four-bit select with the same rates.
// - Timer and one-shot modes use the limit value as lower count bound.
// - Event mode uses limit as upper bound counting up, lower counting down.
// - A limit written while running takes effect at the next wrap, or at the next selected edge in measurement mode.
// - The read-only count register returns the live counter in every mode.
// - Mode field selects timer, event, one-shot or measurement.
// - Event wraps roll to 0000h or FFFFh; timer rolls to 0000h, or reloads limit with reload control; one-shot and measurement reload limit.
// - In event mode direction bit 0 counts down and 1 counts up.
// - Polarity bit treats input pin active low at 0, active high at 1.
`timescale 1ns/10ps
module ctcer_timer #(
	parameter bit HAS_PREV = 1'b1
) (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic clk_en,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_wdata,
	output logic [15:0] reg_rdata,
	input wire logic timer_input_pin,
	input wire logic prev_overflow,
	output logic count_wrap
);
	ctcer_pkg::ctcer_st_t st_ff;
	ctcer_pkg::ctcer_st_t nxt_st;
	logic cnt_tick;
	logic filt_tick;
	logic lvl_in;
	logic lvl;
	logic rise;
	logic fall;
	logic edge_hit;
	logic prev_evt;
	logic src_evt;
	logic run;
	logic [15:0] term_up;
	logic [15:0] term_dn;

	// Count-rate and filter-rate tick generators.
	ctcer_prescale u_cnt_div (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.clk_en(clk_en),
		.sel(st_ff.clkev.count_clock_select),
		.tick(cnt_tick)
	);
	ctcer_prescale u_filt_div (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.clk_en(clk_en),
		.sel(st_ff.clkev.filter_clock_select),
		.tick(filt_tick)
	);

	// Input conditioning, edge selection and event source.
	assign lvl_in = st_ff.ctrl.input_polarity ? timer_input_pin : ~timer_input_pin;
	assign lvl = st_ff.ctrl.filter_bypass ? lvl_in : st_ff.filt;
	assign rise = lvl & ~st_ff.lvl_prev;
	assign fall = ~lvl & st_ff.lvl_prev;
	assign prev_evt = HAS_PREV & prev_overflow;
	assign src_evt = st_ff.clkev.event_source ? edge_hit : prev_evt;
	assign run = st_ff.ctrl.enable & ~st_ff.ctrl.power_down;
	assign term_up = st_ff.ctrl.wrap_reload_control ? st_ff.lim_act : ctcer_pkg::CNT_MAX;
	assign term_dn = st_ff.ctrl.wrap_reload_control ? st_ff.lim_act : ctcer_pkg::CNT_MIN;

	// Edge field decode shared by event, one-shot and measurement modes.
	always_comb
	begin
		case (st_ff.clkev.edge_type)
			ctcer_pkg::EDGE_FALL: edge_hit = fall;
			ctcer_pkg::EDGE_RISE: edge_hit = rise;
			ctcer_pkg::EDGE_BOTH: edge_hit = rise | fall;
			default: edge_hit = 1'b0;
		endcase
	end

	// Next-state logic: filter, counter machine, limit latch, then register writes and reads.
	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.wrap = 1'b0;
		nxt_st.lvl_prev = lvl;
		if (filt_tick)
		begin
			nxt_st.samp = {st_ff.samp[0], lvl_in};
			if (st_ff.samp[1] == st_ff.samp[0])
			begin
				nxt_st.filt = st_ff.samp[0];
			end
		end
		if (st_ff.ctrl.soft_reset)
		begin
			nxt_st.count = st_ff.limit;
			nxt_st.lim_act = st_ff.limit;
			nxt_st.ctrl.enable = 1'b0;
			nxt_st.ctrl.soft_reset = 1'b0;
			nxt_st.os_run = 1'b0;
		end
		else
		begin
			case (st_ff.ctrl.mode)
				ctcer_pkg::MODE_TIMER:
				begin
					if (run && cnt_tick)
					begin
						if (st_ff.count == ctcer_pkg::CNT_MAX)
						begin
							nxt_st.wrap = 1'b1;
							// Reload from the limit, the lower bound here, with reload control; else roll to zero.
							nxt_st.count = st_ff.ctrl.wrap_reload_control ?
								st_ff.limit : ctcer_pkg::CNT_MIN;
						end
						else
						begin
							nxt_st.count = st_ff.count + ctcer_pkg::CNT_ONE;
						end
					end
				end
				ctcer_pkg::MODE_EVENT:
				begin
					if (run && src_evt)
					begin
						if (st_ff.ctrl.count_direction)
						begin
							if (st_ff.count == term_up)
							begin
								nxt_st.wrap = 1'b1;
								nxt_st.count = ctcer_pkg::CNT_MIN;
							end
							else
							begin
								nxt_st.count = st_ff.count + ctcer_pkg::CNT_ONE;
							end
						end
						else if (st_ff.count == term_dn)
						begin
							nxt_st.wrap = 1'b1;
							nxt_st.count = ctcer_pkg::CNT_MAX;
						end
						else
						begin
							nxt_st.count = st_ff.count - ctcer_pkg::CNT_ONE;
						end
					end
				end
				ctcer_pkg::MODE_ONESHOT:
				begin
					// Start trigger clears enable; edge code 11 starts at once.
					if (run && !st_ff.os_run &&
						(st_ff.clkev.edge_type == ctcer_pkg::EDGE_NONE || edge_hit))
					begin
						nxt_st.os_run = 1'b1;
						nxt_st.ctrl.enable = 1'b0;
					end
					if (st_ff.os_run && cnt_tick && !st_ff.ctrl.power_down)
					begin
						if (st_ff.count == ctcer_pkg::CNT_MAX)
						begin
							nxt_st.wrap = 1'b1;
							nxt_st.os_run = 1'b0;
							nxt_st.count = st_ff.limit;
						end
						else
						begin
							nxt_st.count = st_ff.count + ctcer_pkg::CNT_ONE;
						end
					end
				end
				default:
				begin
					// Each selected edge restarts the interval from the limit value.
					if (run && edge_hit)
					begin
						nxt_st.count = st_ff.limit;
					end
					else if (run && cnt_tick)
					begin
						if (st_ff.count == ctcer_pkg::CNT_MAX)
						begin
							nxt_st.wrap = 1'b1;
							nxt_st.count = st_ff.limit;
						end
						else
						begin
							nxt_st.count = st_ff.count + ctcer_pkg::CNT_ONE;
						end
					end
				end
			endcase
			// A new limit reaches the compare only when idle or at a wrap.
			if (!(run || st_ff.os_run) || nxt_st.wrap)
			begin
				nxt_st.lim_act = st_ff.limit;
			end
		end
		nxt_st.ctrl.clk_req = run | nxt_st.os_run;
		if (reg_wr)
		begin
			if (reg_addr == ctcer_pkg::OFS_CTRL)
			begin
				nxt_st.ctrl = (reg_wdata & ctcer_pkg::CTRL_WR_MASK) |
					(nxt_st.ctrl & ~ctcer_pkg::CTRL_WR_MASK);
			end
			else if (reg_addr == ctcer_pkg::OFS_CLKEV)
			begin
				nxt_st.clkev = reg_wdata & ctcer_pkg::CLKEV_WR_MASK;
			end
			else if (reg_addr == ctcer_pkg::OFS_LIMIT)
			begin
				nxt_st.limit = reg_wdata;
			end
		end
		if (reg_rd)
		begin
			if (reg_addr == ctcer_pkg::OFS_CTRL)
			begin
				nxt_st.rdata = st_ff.ctrl;
			end
			else if (reg_addr == ctcer_pkg::OFS_CLKEV)
			begin
				nxt_st.rdata = st_ff.clkev;
			end
			else if (reg_addr == ctcer_pkg::OFS_LIMIT)
			begin
				nxt_st.rdata = st_ff.limit;
			end
			else if (reg_addr == ctcer_pkg::OFS_COUNT)
			begin
				nxt_st.rdata = st_ff.count;
			end
			else
			begin
				nxt_st.rdata = ctcer_pkg::RD_ZERO;
			end
		end
	end

	// State register, frozen while the clock enable is low.
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			st_ff <= '0;
			st_ff.ctrl <= ctcer_pkg::CTRL_RESET;
			st_ff.clkev <= ctcer_pkg::CLKEV_RESET;
			st_ff.limit <= ctcer_pkg::LIMIT_RESET;
			st_ff.lim_act <= ctcer_pkg::LIMIT_RESET;
			st_ff.count <= ctcer_pkg::COUNT_RESET;
		end
		else if (clk_en)
		begin
			st_ff <= nxt_st;
		end
	end

	assign reg_rdata = st_ff.rdata;
	assign count_wrap = st_ff.wrap;

	// Checks on the counting behaviour.
	AST_RSV_SEL_NO_COUNT: assert property (@(posedge ref_clk) disable iff (!arst_n)
		clk_en && st_ff.ctrl.mode == ctcer_pkg::MODE_TIMER && st_ff.clkev.count_clock_select[3]
		&& !st_ff.ctrl.soft_reset |=> st_ff.count == $past(st_ff.count))
		else $error("Reserved clock select still advanced the count.");
	AST_EDGE_NONE_EVENT: assert property (@(posedge ref_clk) disable iff (!arst_n)
		clk_en && st_ff.ctrl.mode == ctcer_pkg::MODE_EVENT && st_ff.clkev.event_source
		&& st_ff.clkev.edge_type == ctcer_pkg::EDGE_NONE && !st_ff.ctrl.soft_reset
		|=> $stable(st_ff.count))
		else $error("Event count moved with no edge selected.");
	AST_ONESHOT_IMMEDIATE: assert property (@(posedge ref_clk) disable iff (!arst_n)
		clk_en && st_ff.ctrl.mode == ctcer_pkg::MODE_ONESHOT && run && !st_ff.os_run
		&& st_ff.clkev.edge_type == ctcer_pkg::EDGE_NONE && !st_ff.ctrl.soft_reset
		|=> st_ff.os_run && !st_ff.ctrl.enable)
		else $error("One-shot did not start at once on enable.");
	AST_MEASURE_RESTART: assert property (@(posedge ref_clk) disable iff (!arst_n)
		clk_en && st_ff.ctrl.mode == ctcer_pkg::MODE_MEASURE && run && edge_hit
		&& !st_ff.ctrl.soft_reset |=> st_ff.count == $past(st_ff.limit))
		else $error("Measured edge did not restart the interval.");
	AST_PREV_SOURCE_IDLE: assert property (@(posedge ref_clk) disable iff (!arst_n)
		clk_en && st_ff.ctrl.mode == ctcer_pkg::MODE_EVENT && !st_ff.clkev.event_source
		&& !prev_evt && !st_ff.ctrl.soft_reset |=> $stable(st_ff.count))
		else $error("Event count moved without a predecessor overflow.");
	AST_TIMER_ROLL: assert property (@(posedge ref_clk) disable iff (!arst_n)
		clk_en && st_ff.ctrl.mode == ctcer_pkg::MODE_TIMER && run && cnt_tick
		&& st_ff.count == ctcer_pkg::CNT_MAX && !st_ff.ctrl.wrap_reload_control
		&& !st_ff.ctrl.soft_reset |=> st_ff.count == ctcer_pkg::CNT_MIN && count_wrap)
		else $error("Timer did not roll to zero with a wrap pulse.");
	AST_EVENT_DOWN_STEP: assert property (@(posedge ref_clk) disable iff (!arst_n)
		clk_en && st_ff.ctrl.mode == ctcer_pkg::MODE_EVENT && run && src_evt
		&& !st_ff.ctrl.count_direction && st_ff.count != term_dn && !st_ff.ctrl.soft_reset
		|=> st_ff.count == $past(st_ff.count) - ctcer_pkg::CNT_ONE)
		else $error("Event count did not step down by one.");
	AST_EVENT_UP_LIMIT: assert property (@(posedge ref_clk) disable iff (!arst_n)
		clk_en && st_ff.ctrl.mode == ctcer_pkg::MODE_EVENT && run && src_evt
		&& st_ff.ctrl.count_direction && st_ff.ctrl.wrap_reload_control
		&& st_ff.count == st_ff.lim_act && !st_ff.ctrl.soft_reset
		|=> st_ff.count == ctcer_pkg::CNT_MIN && count_wrap)
		else $error("Event count passed its upper limit.");
	AST_LIMIT_DEFERRED: assert property (@(posedge ref_clk) disable iff (!arst_n)
		clk_en && reg_wr && reg_addr == ctcer_pkg::OFS_LIMIT && run && !nxt_st.wrap
		&& !st_ff.ctrl.soft_reset |=> $stable(st_ff.lim_act))
		else $error("Limit took effect before the wrap.");
	AST_COUNT_READ: assert property (@(posedge ref_clk) disable iff (!arst_n)
		clk_en && reg_rd && reg_addr == ctcer_pkg::OFS_COUNT
		|=> reg_rdata == $past(st_ff.count))
		else $error("Count read did not return the live counter.");
endmodule // ctcer_timer

/* sim/ctcer_far_model.sv */
// Far-side model that drives the external input pin and the preceding instance's wrap pulse.
`timescale 1ns/10ps
module ctcer_far_model (
	input wire logic ref_clk,
	output logic timer_input_pin,
	output logic prev_overflow
);
	// Both lines start idle; the pin is a plain level that is synchronous to the clock.
	initial
	begin
		timer_input_pin = 1'b0;
		prev_overflow = 1'b0;
	end

	// Moves the pin just after an edge and keeps it there until told otherwise.
	task automatic set_pin(input logic v);
		@(posedge ref_clk);
		#1 timer_input_pin = v;
	endtask

	// The preceding instance reports each wrap as a single-cycle pulse.
	task automatic pulse_prev();
		@(posedge ref_clk);
		#1 prev_overflow = 1'b1;
		@(posedge ref_clk);
		#1 prev_overflow = 1'b0;
	endtask
endmodule // ctcer_far_model

/* sim/ctcer_timer_tb_top.sv */
// Self-checking bench for the counter/timer instance and its far-side model.
`timescale 1ns/10ps
module ctcer_timer_tb_top;
	typedef struct {logic [7:0] addr; logic [15:0] wdata; logic [15:0] exp;} ctcer_row_t;
	logic ref_clk = 1'b0;
	logic arst_n = 1'b0;
	logic clk_en = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [15:0] reg_wdata = 16'h0000;
	logic [15:0] reg_rdata, first_rdata, c0, f0;
	logic timer_input_pin, prev_overflow, count_wrap;
	int error_cnt = 0;
	int checks_done = 0;
	int cyc;
	ctcer_row_t rows [6] = '{'{8'h08, 16'h1234, 16'h1234}, '{8'h04, 16'hffff, 16'h0fef},
		'{8'h04, 16'h0000, 16'h0000}, '{8'h0c, 16'h0000, 16'hffff},
		'{8'h10, 16'h5555, 16'h0000}, '{8'h00, 16'h0700, 16'h0700}};
	logic [15:0] rst_vals [4] = '{ctcer_pkg::CTRL_RESET, ctcer_pkg::CLKEV_RESET,
		ctcer_pkg::LIMIT_RESET, ctcer_pkg::COUNT_RESET};

	// Free-running 125 MHz clock.
	always #4 ref_clk = ~ref_clk;

	// Instance under test, plus a first-in-chain instance sharing every input.
	ctcer_timer i_dut (.ref_clk(ref_clk), .arst_n(arst_n), .clk_en(clk_en),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .timer_input_pin(timer_input_pin),
		.prev_overflow(prev_overflow), .count_wrap(count_wrap));
	ctcer_timer #(.HAS_PREV(1'b0)) i_first (.ref_clk(ref_clk), .arst_n(arst_n),
		.clk_en(clk_en), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_wdata(reg_wdata), .reg_rdata(first_rdata), .timer_input_pin(timer_input_pin),
		.prev_overflow(prev_overflow), .count_wrap());
	ctcer_far_model i_far (.ref_clk(ref_clk), .timer_input_pin(timer_input_pin),
		.prev_overflow(prev_overflow));

	// Prints the counts and the verdict, then stops the run.
	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Compares one 16-bit result with case equality so unknowns never match.
	task automatic check16(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks_done++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Marks the end of one test.
	task automatic done(input string s);
		$display("test done: %s", s);
	endtask

	// Register write; the idle cycle at the end keeps strobes from being reassigned at once.
	task automatic wr(input logic [7:0] a, input logic [15:0] v);
		reg_addr = a;
		reg_wdata = v;
		reg_wr = 1'b1;
		@(posedge ref_clk);
		#1 reg_wr = 1'b0;
		@(posedge ref_clk);
		#1;
	endtask

	// Register read; data is registered and valid just after the taking edge.
	task automatic rd(input logic [7:0] a);
		reg_addr = a;
		reg_rd = 1'b1;
		@(posedge ref_clk);
		#1 reg_rd = 1'b0;
		@(posedge ref_clk);
		#1;
	endtask

	// Counts cycles until the wrap pulse, giving up after a fixed bound.
	task automatic wait_wrap(output int n);
		n = 0;
		do
		begin
			@(posedge ref_clk);
			#1 n++;
			if (n > 5000)
			begin
				error_cnt++;
				$display("Error wrap_wait expected %h seen %h", 1'b1, count_wrap);
				finish_test();
			end
		end while (count_wrap !== 1'b1);
	endtask

	// Applies one far-side action and checks the count change of both instances.
	task automatic step(input int act, input logic [15:0] exp);
		rd(8'h0c);
		c0 = reg_rdata;
		f0 = first_rdata;
		if (act == 2)
			i_far.pulse_prev();
		else
			i_far.set_pin(act[0]);
		repeat (4) @(posedge ref_clk);
		#1 rd(8'h0c);
		check16("count_step", exp, reg_rdata - c0);
		check16("first_step", (act == 2) ? 16'h0000 : exp, first_rdata - f0);
	endtask

	// Main sequence: register rows, then reset and the hand-written cases.
	initial
	begin
		repeat (6) @(posedge ref_clk);
		#1 arst_n = 1'b1;
		foreach (rows[i])
		begin
			wr(rows[i].addr, rows[i].wdata);
			rd(rows[i].addr);
			check16("reg_rw", rows[i].exp, reg_rdata);
		end
		done("register rows");
		arst_n = 1'b0;
		repeat (2) @(posedge ref_clk);
		#1 arst_n = 1'b1;
		for (int i = 0; i < 4; i++)
		begin
			rd(8'(i * 4));
			check16("reset_val", rst_vals[i], reg_rdata);
		end
		done("reset values");
		wr(8'h08, 16'hfff0);
		wr(8'h00, 16'h0001);
		// The first tick wraps at once, so the pulse stands as the write ends.
		check16("roll_pulse", 16'h0001, {15'h0000, count_wrap});
		rd(8'h0c);
		check16("roll_value", 16'h0000, reg_rdata);
		wr(8'h00, 16'h0002);
		wr(8'h00, 16'h0081);
		for (int n = 0; n < 8; n++)
		begin
			wr(8'h04, 16'(n));
			wait_wrap(cyc);
			wait_wrap(cyc);
			check16("wrap_period", 16'(16 << n), 16'(cyc));
			rd(8'h0c);
			check16("reload_value", 16'hfff0, reg_rdata);
		end
		wr(8'h04, 16'h0008);
		rd(8'h0c);
		c0 = reg_rdata;
		repeat (300) @(posedge ref_clk);
		#1 rd(8'h0c);
		check16("reserved_rate", c0, reg_rdata);
		done("timer rates");
		wr(8'h08, 16'h8000);
		wr(8'h00, 16'h0102);
		wr(8'h00, 16'h0135);
		for (int e = 0; e < 4; e++)
		begin
			wr(8'h04, {8'h00, 1'b1, 2'(e), 5'h00});
			step(1, {15'h0000, e == 1 || e == 2});
			step(0, {15'h0000, e == 0 || e == 2});
		end
		wr(8'h00, 16'h0125);
		wr(8'h04, 16'h00a0);
		step(1, 16'h0000);
		step(0, 16'h0001);
		wr(8'h00, 16'h0115);
		step(1, 16'hffff);
		step(0, 16'h0000);
		wr(8'h00, 16'h0135);
		wr(8'h04, 16'h0020);
		step(2, 16'h0001);
		step(1, 16'h0000);
		step(0, 16'h0000);
		done("event counting");
		wr(8'h08, 16'hfff0);
		wr(8'h00, 16'h0102);
		wr(8'h04, 16'h0060);
		wr(8'h00, 16'h0109);
		wait_wrap(cyc);
		repeat (20) @(posedge ref_clk);
		#1 rd(8'h0c);
		check16("oneshot_stop", 16'hfff0, reg_rdata);
		rd(8'h00);
		check16("oneshot_ctrl", 16'h0108, reg_rdata);
		wr(8'h04, 16'h0020);
		wr(8'h00, 16'h0119);
		repeat (20) @(posedge ref_clk);
		#1 rd(8'h0c);
		check16("oneshot_wait", 16'hfff0, reg_rdata);
		i_far.set_pin(1'b1);
		wait_wrap(cyc);
		rd(8'h00);
		check16("oneshot_edge", 16'h0118, reg_rdata);
		done("one-shot");
		// Measurement: a selected rising edge restarts the interval from the limit.
		wr(8'h08, 16'h1000);
		wr(8'h00, 16'h0102);
		wr(8'h00, 16'h011d);
		i_far.set_pin(1'b0);
		i_far.set_pin(1'b1);
		repeat (8) @(posedge ref_clk);
		#1 rd(8'h0c);
		check16("measure_restart", 16'h1007, reg_rdata);
		done("measurement");
		// Filter: a one-cycle glitch is rejected, a held level passes.
		wr(8'h00, 16'h0035);
		i_far.set_pin(1'b0);
		wr(8'h04, 16'h02a0);
		repeat (20) @(posedge ref_clk);
		#1 rd(8'h0c);
		c0 = reg_rdata;
		i_far.set_pin(1'b1);
		i_far.set_pin(1'b0);
		repeat (20) @(posedge ref_clk);
		#1 rd(8'h0c);
		check16("filter_glitch", c0, reg_rdata);
		i_far.set_pin(1'b1);
		repeat (20) @(posedge ref_clk);
		#1 rd(8'h0c);
		check16("filter_pass", c0 + 16'h0001, reg_rdata);
		// Event limit: a limit written while running waits for the next wrap.
		wr(8'h00, 16'h0002);
		wr(8'h04, 16'h0020);
		wr(8'h00, 16'h00a5);
		wr(8'h08, 16'h2000);
		step(2, 16'hf000);
		done("filter and event limit");
		finish_test();
	end
endmodule // ctcer_timer_tb_top
